// *** src/wscr_regs.svh ***
// Register map, field masks and reset values of the wake source bank.
// Assumes inclusion by bare name from the design and bench files.
`ifndef WSCR_REGS_SVH
`define WSCR_REGS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define WSCR_IDX_BUS2 6'h05
`define WSCR_IDX_TWAKE 6'h06
`define WSCR_IDX_EWAKE 6'h07
`define WSCR_IDX_BIAS 6'h08
`define WSCR_IDX_IRQ_STAT 6'h0C
`define WSCR_IDX_IRQ_CLR 6'h0D
`define WSCR_IDX_IRQ_EN 6'h0E
`define WSCR_IDX_NONE 6'h3F

// ----------------------------------------------------------------------
// Bus access
// ----------------------------------------------------------------------
`define WSCR_HSIZE_WORD 3'h2

// ----------------------------------------------------------------------
// Writable bit masks (reserved bits are zero here)
// ----------------------------------------------------------------------
`define WSCR_BUS2_MASK 8'h23
`define WSCR_TWAKE_MASK 8'hC4
`define WSCR_EWAKE_MASK 8'hA7
`define WSCR_BIAS_MASK 8'h3F
`define WSCR_BUS2_SECOND_LIN_TRANSCEIVER_MODE_MASK 8'h03
`define WSCR_BUS2_PEAK_MASK 8'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WSCR_PEAK_BIT 5
`define WSCR_T2_WK_BIT 7
`define WSCR_T1_WK_BIT 6
`define WSCR_WD_STOP_BIT 2
`define WSCR_GLOBAL_BIT 7
`define WSCR_MEAS_BIT 5

// ----------------------------------------------------------------------
// Reset and fail-safe values
// ----------------------------------------------------------------------
`define WSCR_BUS2_RST 8'h00
`define WSCR_TWAKE_RST 8'h00
`define WSCR_EWAKE_RST 8'h07
`define WSCR_BIAS_RST 8'h00
`define WSCR_BUS2_FS 8'h01
`define WSCR_EWAKE_FS_KEEP 8'hA0
`define WSCR_EWAKE_FS_SET 8'h07
`define WSCR_BUS1_FS_LOW 5'h09

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define WSCR_IRQ_W 3
`define WSCR_EV_FAILSAFE 0
`define WSCR_EV_SECOND_LIN_TRANSCEIVER_MODE_UPD 1
`define WSCR_EV_WD_UPD 2

`endif

// *** src/wscr_pkg.sv ***
// Types shared by the wake source register bank.
// Assumes the mode sequencer drives one-hot mode codes.
package wscr_pkg;

   // Chip operating mode, one-hot
   typedef enum logic [4:0] {
      WSCR_MODE_INIT = 5'h01,
      WSCR_MODE_NORMAL = 5'h02,
      WSCR_MODE_STOP = 5'h04,
      WSCR_MODE_SLEEP = 5'h08,
      WSCR_MODE_FAILSAFE = 5'h10
   } wscr_mode_type;

endpackage

// *** src/wscr_ahb_slave.sv ***
// AHB-Lite slave front end: address phase capture and wait control.
// Assumes a single slave whose hreadyout is the bus hready.
`timescale 1ns/10ps
`include "wscr_regs.svh"

module wscr_ahb_slave (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   // Register side
   output logic [5:0] idx_o,
   output logic wr_en_o,
   output logic rd_load_o
);
   import wscr_pkg::*;

   logic accept;
   logic aligned;
   logic [5:0] idx_next;
   logic wr_reg;
   logic rd_reg;
   logic [5:0] idx_reg;

   // Odd sizes or addresses fall to an unmapped index
   assign accept = hsel_i & htrans_i[1] & hready_i;
   assign aligned = (haddr_i[31:8] == 24'h000000) && (haddr_i[1:0] == 2'h0)
                    && (hsize_i == `WSCR_HSIZE_WORD);
   assign idx_next = aligned ? haddr_i[7:2] : `WSCR_IDX_NONE;

   // Data phase flags; reads take one wait so hrdata comes from a flop
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         idx_reg <= 6'h00;
      end else begin
         wr_reg <= accept & hwrite_i;
         rd_reg <= accept & ~hwrite_i;
         if (accept) begin
            idx_reg <= idx_next;
         end
      end
   end

   // Outputs
   assign hreadyout_o = ~rd_reg;
   assign hresp_o = 1'b0;
   assign idx_o = idx_reg;
   assign wr_en_o = wr_reg;
   assign rd_load_o = rd_reg;
endmodule

// *** src/wscr_irq.sv ***
// Sticky event status, enable mask and level interrupt.
// Assumes event pulses and writes are in the clk_sys_i domain.
`timescale 1ns/10ps
`include "wscr_regs.svh"

module wscr_irq (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Events and software access
   input wire logic [`WSCR_IRQ_W-1:0] event_i,
   input wire logic clr_wr_i,
   input wire logic en_wr_i,
   input wire logic [`WSCR_IRQ_W-1:0] wdata_i,
   // State
   output logic [`WSCR_IRQ_W-1:0] status_o,
   output logic [`WSCR_IRQ_W-1:0] enable_o,
   output logic irq_o
);
   import wscr_pkg::*;

   logic [`WSCR_IRQ_W-1:0] status_reg;
   logic [`WSCR_IRQ_W-1:0] status_next;
   logic [`WSCR_IRQ_W-1:0] enable_reg;
   logic [`WSCR_IRQ_W-1:0] clr_mask;

   // Set beats clear so an event landing on a clear is kept
   assign clr_mask = clr_wr_i ? wdata_i : '0;
   assign status_next = (status_reg & ~clr_mask) | event_i;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_reg <= '0;
         enable_reg <= '0;
      end else begin
         status_reg <= status_next;
         if (en_wr_i) begin
            enable_reg <= wdata_i;
         end
      end
   end

   assign status_o = status_reg;
   assign enable_o = enable_reg;
   assign irq_o = |(status_reg & enable_reg);
endmodule

// *** src/wscr_top.sv ***
// Wake source and bus option register bank reached over AHB-Lite.
// Assumes mode and device-side update strobes come from the mode
// sequencer on clk_sys_i; update strobes are one-cycle pulses.
`timescale 1ns/10ps
`include "wscr_regs.svh"

module wscr_top (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Mode sequencer side
   input wire wscr_pkg::wscr_mode_type sbc_mode_i,
   input wire logic soft_reset_i,
   input wire logic failsafe_entry_i,
   input wire logic restart_i,
   input wire logic [1:0] restart_second_lin_transceiver_mode_i,
   input wire logic second_lin_transceiver_mode_upd_i,
   input wire logic [1:0] second_lin_transceiver_mode_upd_val_i,
   input wire logic wd_upd_i,
   input wire logic wd_upd_val_i,
   // Configuration outputs
   output logic [1:0] second_lin_transceiver_mode_o,
   output logic supply_peak_threshold_select_o,
   output logic second_timer_wake_enable_o,
   output logic first_timer_wake_enable_o,
   output logic watchdog_stop_disable_high_o,
   output logic int_global_o,
   output logic [2:0] wake_src_en_o,
   output logic measure_active_o,
   output logic [1:0] wake_level_valid_o,
   output logic [1:0] wake_input_three_bias_o,
   output logic [1:0] wake_input_two_bias_o,
   output logic [1:0] wake_input_one_bias_o,
   output logic first_bus_force_o,
   output logic [4:0] first_bus_force_val_o,
   // Interrupt
   output logic irq_o
);
   import wscr_pkg::*;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [5:0] idx;
   logic wr_en;
   logic rd_load;
   logic [7:0] wdata;
   logic [7:0] bus2_reg;
   logic [7:0] bus2_next;
   logic [7:0] bus2_host;
   logic [7:0] bus2_wr_val;
   logic [7:0] bus2_dev;
   logic [7:0] bus2_restart;
   logic [7:0] twake_reg;
   logic [7:0] twake_next;
   logic [7:0] twake_host;
   logic [7:0] ewake_reg;
   logic [7:0] ewake_next;
   logic [7:0] ewake_host;
   logic [7:0] ewake_fs;
   logic [7:0] bias_reg;
   logic [7:0] bias_next;
   logic [31:0] hrdata_reg;
   logic [31:0] hrdata_next;
   logic [7:0] rd_val;
   logic fs_force_reg;
   logic peak_open;
   logic wr_bus2;
   logic wr_twake;
   logic wr_ewake;
   logic wr_bias;
   logic wr_irq_clr;
   logic wr_irq_en;
   logic [`WSCR_IRQ_W-1:0] irq_event;
   logic [`WSCR_IRQ_W-1:0] irq_status;
   logic [`WSCR_IRQ_W-1:0] irq_enable;

   // ----------------------------------------------------------------------
   // Bus front end and address decode
   // ----------------------------------------------------------------------
   function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
      hit = (a == b);
   endfunction

   // Bus slave instance
   wscr_ahb_slave u_slave (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .hsel_i(hsel_i),
      .haddr_i(haddr_i),
      .htrans_i(htrans_i),
      .hwrite_i(hwrite_i),
      .hsize_i(hsize_i),
      .hready_i(hready_i),
      .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o),
      .idx_o(idx),
      .wr_en_o(wr_en),
      .rd_load_o(rd_load)
   );

   // Write strobes per register
   assign wdata = hwdata_i[7:0];
   assign wr_bus2 = wr_en & hit(idx, `WSCR_IDX_BUS2);
   assign wr_twake = wr_en & hit(idx, `WSCR_IDX_TWAKE);
   assign wr_ewake = wr_en & hit(idx, `WSCR_IDX_EWAKE);
   assign wr_bias = wr_en & hit(idx, `WSCR_IDX_BIAS);
   assign wr_irq_clr = wr_en & hit(idx, `WSCR_IDX_IRQ_CLR);
   assign wr_irq_en = wr_en & hit(idx, `WSCR_IDX_IRQ_EN);

   // ----------------------------------------------------------------------
   // Second bus control register
   // ----------------------------------------------------------------------
   // Peak bit open to software only in Init or Normal
   assign peak_open = (sbc_mode_i == WSCR_MODE_INIT) ||
                      (sbc_mode_i == WSCR_MODE_NORMAL);
   // Closed peak bit silently keeps its value, nothing is flagged
   assign bus2_wr_val = peak_open ? (wdata & `WSCR_BUS2_MASK) :
                        ((bus2_reg & `WSCR_BUS2_PEAK_MASK) |
                         (wdata & `WSCR_BUS2_SECOND_LIN_TRANSCEIVER_MODE_MASK));
   assign bus2_host = wr_bus2 ? bus2_wr_val : bus2_reg;
   // Device update overrides the host's mode bits in the same cycle
   assign bus2_dev = second_lin_transceiver_mode_upd_i ? {bus2_host[7:2], second_lin_transceiver_mode_upd_val_i} :
                     bus2_host;
   // Restart keeps the peak bit, mode comes from the sequencer
   assign bus2_restart = (bus2_reg & `WSCR_BUS2_PEAK_MASK) |
                         {6'h00, restart_second_lin_transceiver_mode_i};
   assign bus2_next = soft_reset_i ? `WSCR_BUS2_RST :
                      failsafe_entry_i ? `WSCR_BUS2_FS :
                      restart_i ? bus2_restart : bus2_dev;

   // ----------------------------------------------------------------------
   // Timer wake and watchdog register
   // ----------------------------------------------------------------------
   // Watchdog bit takes the device value ahead of a host write
   assign twake_host = wr_twake ? (wdata & `WSCR_TWAKE_MASK) : twake_reg;
   always_comb begin
      twake_next = twake_host;
      if (wd_upd_i) begin
         twake_next[`WSCR_WD_STOP_BIT] = wd_upd_val_i;
      end
      if (soft_reset_i) begin
         twake_next = `WSCR_TWAKE_RST;
      end
   end

   // ----------------------------------------------------------------------
   // External wake register and bias register
   // ----------------------------------------------------------------------
   assign ewake_host = wr_ewake ? (wdata & `WSCR_EWAKE_MASK) : ewake_reg;
   // Fail-safe keeps global and measure bits, sets all three wake enable bits
   assign ewake_fs = (ewake_reg & `WSCR_EWAKE_FS_KEEP) |
                     `WSCR_EWAKE_FS_SET;
   // Restart clears only reserved bits, which the mask already zeroes
   assign ewake_next = soft_reset_i ? `WSCR_EWAKE_RST :
                       failsafe_entry_i ? ewake_fs :
                       restart_i ? (ewake_reg & `WSCR_EWAKE_MASK) :
                       ewake_host;
   assign bias_next = soft_reset_i ? `WSCR_BIAS_RST :
                      wr_bias ? (wdata & `WSCR_BIAS_MASK) : bias_reg;

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   // Power-on values on the asynchronous reset
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bus2_reg <= `WSCR_BUS2_RST;
         twake_reg <= `WSCR_TWAKE_RST;
         ewake_reg <= `WSCR_EWAKE_RST;
         bias_reg <= `WSCR_BIAS_RST;
         fs_force_reg <= 1'b0;
      end else begin
         bus2_reg <= bus2_next;
         twake_reg <= twake_next;
         ewake_reg <= ewake_next;
         bias_reg <= bias_next;
         fs_force_reg <= failsafe_entry_i & ~soft_reset_i;
      end
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   // Unmapped and write-only indices read as zero
   assign rd_val = hit(idx, `WSCR_IDX_BUS2) ? bus2_reg :
                   hit(idx, `WSCR_IDX_TWAKE) ? twake_reg :
                   hit(idx, `WSCR_IDX_EWAKE) ? ewake_reg :
                   hit(idx, `WSCR_IDX_BIAS) ? bias_reg :
                   hit(idx, `WSCR_IDX_IRQ_STAT) ? {5'h00, irq_status} :
                   hit(idx, `WSCR_IDX_IRQ_EN) ? {5'h00, irq_enable} :
                   8'h00;
   assign hrdata_next = rd_load ? {24'h000000, rd_val} : hrdata_reg;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hrdata_reg <= 32'h00000000;
      end else begin
         hrdata_reg <= hrdata_next;
      end
   end
   assign hrdata_o = hrdata_reg;

   // ----------------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------------
   // Ignored Stop-mode peak writes are deliberately not an event
   assign irq_event[`WSCR_EV_FAILSAFE] = failsafe_entry_i;
   assign irq_event[`WSCR_EV_SECOND_LIN_TRANSCEIVER_MODE_UPD] = second_lin_transceiver_mode_upd_i;
   assign irq_event[`WSCR_EV_WD_UPD] = wd_upd_i;

   wscr_irq u_irq (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .event_i(irq_event),
      .clr_wr_i(wr_irq_clr),
      .en_wr_i(wr_irq_en),
      .wdata_i(wdata[`WSCR_IRQ_W-1:0]),
      .status_o(irq_status),
      .enable_o(irq_enable),
      .irq_o(irq_o)
   );

   // ----------------------------------------------------------------------
   // Configuration outputs
   // ----------------------------------------------------------------------
   // Field outputs straight from the registers
   assign second_lin_transceiver_mode_o = bus2_reg[1:0];
   assign supply_peak_threshold_select_o = bus2_reg[`WSCR_PEAK_BIT];
   assign second_timer_wake_enable_o = twake_reg[`WSCR_T2_WK_BIT];
   assign first_timer_wake_enable_o = twake_reg[`WSCR_T1_WK_BIT];
   assign watchdog_stop_disable_high_o = twake_reg[`WSCR_WD_STOP_BIT];
   assign int_global_o = ewake_reg[`WSCR_GLOBAL_BIT];
   // Measure mode masks enables 1 and 0, not enable 2, but leaves the stored bits alone
   assign wake_src_en_o[2] = ewake_reg[2];
   assign wake_src_en_o[1:0] = ewake_reg[1:0] &
                               {2{~ewake_reg[`WSCR_MEAS_BIT]}};
   assign measure_active_o = ewake_reg[`WSCR_MEAS_BIT] &
                             (sbc_mode_i == WSCR_MODE_NORMAL);
   assign wake_level_valid_o = {2{~ewake_reg[`WSCR_MEAS_BIT]}};
   // Codes: 00 none, 01 down, 10 up, 11 automatic
   assign wake_input_three_bias_o = bias_reg[5:4];
   assign wake_input_two_bias_o = bias_reg[3:2];
   assign wake_input_one_bias_o = bias_reg[1:0];
   // First bus register lives elsewhere; LIN 01 and CAN 001 wake capable
   assign first_bus_force_o = fs_force_reg;
   assign first_bus_force_val_o = `WSCR_BUS1_FS_LOW;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   logic quiet;
   assign quiet = ~soft_reset_i & ~failsafe_entry_i & ~restart_i;

   a_rsvd_read_zero: assert property (
      rd_load |=> hrdata_o[31:8] == 24'h000000 &&
      (hit($past(idx), `WSCR_IDX_BUS2) -> (hrdata_o[7:0] & ~`WSCR_BUS2_MASK) == 8'h00))
      else $error("reserved bits read back nonzero");

   a_peak_open_write: assert property (
      wr_bus2 && peak_open && quiet |=> supply_peak_threshold_select_o == $past(wdata[5]))
      else $error("peak bit not written in open mode");

   a_peak_stop_hold: assert property (
      wr_bus2 && sbc_mode_i == WSCR_MODE_STOP && quiet |=> $stable(bus2_reg[5]))
      else $error("peak bit changed in stop mode");

   a_stop_no_irq: assert property (
      wr_bus2 && !peak_open && irq_event == 3'h0 && !wr_irq_clr |=> $stable(irq_status))
      else $error("stop write raised status");

   a_fs_force_vals: assert property (
      failsafe_entry_i && !soft_reset_i |=> bus2_reg == 8'h01 && ewake_reg[2:0] == 3'h7
      && first_bus_force_o && ewake_reg[6] == 1'b0 ##1 !first_bus_force_o || failsafe_entry_i)
      else $error("fail-safe values not forced");

   a_restart_bus2: assert property (
      restart_i && !soft_reset_i && !failsafe_entry_i |=>
      bus2_reg[7:2] == {2'h0, $past(bus2_reg[5]), 3'h0} &&
      bus2_reg[1:0] == $past(restart_second_lin_transceiver_mode_i))
      else $error("restart value wrong");

   a_soft_reset_vals: assert property (
      soft_reset_i |=> bus2_reg == 8'h00 && ewake_reg == 8'h07 && wake_src_en_o == 3'h7)
      else $error("soft reset values wrong");

   a_meas_mask: assert property (
      ewake_reg[5] |-> wake_src_en_o[1:0] == 2'h0 && wake_level_valid_o == 2'h0)
      else $error("measure mode left wake inputs on");

   a_dev_wins: assert property (
      second_lin_transceiver_mode_upd_i && wr_bus2 && quiet |=> bus2_reg[1:0] == $past(second_lin_transceiver_mode_upd_val_i))
      else $error("host write beat device update");

   a_wd_dev_upd: assert property (
      wd_upd_i && !soft_reset_i |=> watchdog_stop_disable_high_o == $past(wd_upd_val_i))
      else $error("watchdog bit not updated");

   c_failsafe: cover property (failsafe_entry_i ##1 first_bus_force_o);
   c_stop_write: cover property (wr_bus2 && sbc_mode_i == WSCR_MODE_STOP);
   c_read_bus2: cover property (rd_load && hit(idx, `WSCR_IDX_BUS2));
   c_meas_normal: cover property (measure_active_o);
endmodule

// *** testbench/wscr_host.sv ***
// Host model: AHB-Lite master doing single word transfers.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/10ps
module wscr_host (
   // Clock and answer
   input wire logic clk_sys_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_i,
   // Request
   output logic hsel_o,
   output logic [31:0] haddr_o,
   output logic [1:0] htrans_o,
   output logic hwrite_o,
   output logic [2:0] hsize_o,
   output logic [31:0] hwdata_o,
   // Hang flag
   output logic tmo_o
);
   // Idle bus from time zero
   initial begin
      hsel_o = 1'b0;
      haddr_o = 32'h0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hsize_o = 3'h2;
      hwdata_o = 32'h0;
      tmo_o = 1'b0;
   end
   // Bounded wait, so a dead slave cannot hang the run
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clk_sys_i);
      while (hready_i !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk_sys_i);
      end
      if (n == 20) begin
         tmo_o <= 1'b1;
      end
   endtask
   // One transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
      hsel_o <= 1'b1;
      haddr_o <= a;
      htrans_o <= 2'h2;
      hwrite_o <= w;
      wait_rdy();
      htrans_o <= 2'h0;
      hsel_o <= 1'b0;
      hwdata_o <= d;
      wait_rdy();
      r = hrdata_i;
      hwdata_o <= ~d; // Released data must not linger
   endtask
endmodule

// *** testbench/wscr_bench.sv ***
// Self-checking bench of the wake source register bank.
// Assumes the host model owns the bus; the bench plays the mode sequencer.
`timescale 1ns/10ps
`include "wscr_regs.svh"
module wscr_bench;
   import wscr_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel, hwrite, hrdy, hresp, tmo;
   logic [1:0] htrans, second_lin_transceiver_mode, lvl, b3, b2, b1;
   logic [2:0] hsize, wsrc;
   logic [31:0] haddr, hwdata, hrdata, rv;
   wscr_mode_type mode = WSCR_MODE_NORMAL;
   logic [4:0] stb = 5'h00;
   logic [4:0] fbv;
   logic [1:0] val = 2'h0;
   logic peak, t2, t1, wd, glob, meas, fb, fbs, irq;
   logic [5:0] idx [4] = '{6'h05, 6'h06, 6'h07, 6'h08};
   logic [7:0] msk [4] = '{8'h23, 8'hC4, 8'hA7, 8'h3F};
   int miscompares = 0;
   int n_tests = 0;
   // 50 MHz clock
   always #10 clk = ~clk;
   wscr_host i_wscr_host (.clk_sys_i(clk), .hready_i(hrdy), .hrdata_i(hrdata),
      .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
      .hsize_o(hsize), .hwdata_o(hwdata), .tmo_o(tmo));
   wscr_top i_wscr_top (.clk_sys_i(clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hrdy),
      .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
      .sbc_mode_i(mode), .soft_reset_i(stb[0]), .failsafe_entry_i(stb[1]),
      .restart_i(stb[2]), .restart_second_lin_transceiver_mode_i(val), .second_lin_transceiver_mode_upd_i(stb[3]),
      .second_lin_transceiver_mode_upd_val_i(val), .wd_upd_i(stb[4]), .wd_upd_val_i(val[0]),
      .second_lin_transceiver_mode_o(second_lin_transceiver_mode), .supply_peak_threshold_select_o(peak),
      .second_timer_wake_enable_o(t2), .first_timer_wake_enable_o(t1),
      .watchdog_stop_disable_high_o(wd), .int_global_o(glob), .wake_src_en_o(wsrc),
      .measure_active_o(meas), .wake_level_valid_o(lvl), .wake_input_three_bias_o(b3),
      .wake_input_two_bias_o(b2), .wake_input_one_bias_o(b1), .first_bus_force_o(fb),
      .first_bus_force_val_o(fbv), .irq_o(irq));
   // Compare and count
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Extra edge so register outputs have settled on return
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      i_wscr_host.xfer(1'b1, {24'h0, i, 2'h0}, {24'h0, d}, rv);
      @(posedge clk);
   endtask
   task automatic rdc(input logic [5:0] i, input logic [31:0] e);
      i_wscr_host.xfer(1'b0, {24'h0, i, 2'h0}, 32'h0, rv);
      chk(rv, e);
   endtask
   // One-cycle sequencer strobe; force pulse sampled 1 ns after the edge
   task automatic pulse(input logic [4:0] s);
      stb <= s;
      @(posedge clk);
      stb <= 5'h00;
      #1 fbs = fb;
      @(posedge clk);
   endtask
   task automatic conclude();
      $display("tests %0d, miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // A bus wait ran out
   always @(posedge tmo) begin
      miscompares++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc(`WSCR_IDX_BUS2, 32'h00);
      rdc(`WSCR_IDX_TWAKE, 32'h00);
      rdc(`WSCR_IDX_EWAKE, 32'h07);
      rdc(`WSCR_IDX_BIAS, 32'h00);
      chk(32'(wsrc), 32'h7);
      chk(32'(hresp), 32'h0);
      foreach (idx[k]) begin
         wr(idx[k], 8'hFF);
         rdc(idx[k], 32'(msk[k]));
      end
      chk(32'({peak, t2, t1, wd, glob}), 32'h1F);
      chk(32'({wsrc, meas, lvl}), 32'h24);
      mode <= WSCR_MODE_STOP;
      wr(`WSCR_IDX_IRQ_EN, 8'h07);
      chk(32'(meas), 32'h0);
      wr(`WSCR_IDX_BUS2, 8'h00);
      rdc(`WSCR_IDX_BUS2, 32'h20);
      rdc(`WSCR_IDX_IRQ_STAT, 32'h0);
      chk(32'(irq), 32'h0);
      wr(6'h3F, 8'hFF);
      rdc(6'h3F, 32'h0);
      // Init opens the peak bit, Sleep closes it again
      mode <= WSCR_MODE_INIT;
      wr(`WSCR_IDX_BUS2, 8'h00);
      rdc(`WSCR_IDX_BUS2, 32'h00);
      mode <= WSCR_MODE_SLEEP;
      wr(`WSCR_IDX_BUS2, 8'h21);
      rdc(`WSCR_IDX_BUS2, 32'h01);
      mode <= WSCR_MODE_NORMAL;
      // Every mode and bias code, all fields at once
      for (int c = 0; c < 4; c++) begin
         wr(`WSCR_IDX_BUS2, 8'(c));
         wr(`WSCR_IDX_BIAS, 8'(c * 21));
         wr(`WSCR_IDX_EWAKE, 8'(c + 4));
         chk(32'({second_lin_transceiver_mode, b3, b2, b1}), 32'(c * 85));
         chk(32'(wsrc), 32'(c + 4));
      end
      wr(`WSCR_IDX_EWAKE, 8'hA0);
      wr(`WSCR_IDX_BUS2, 8'h22);
      pulse(5'h02);
      chk(32'({fbs, fbv}), 32'h29);
      rdc(`WSCR_IDX_BUS2, 32'h01);
      chk(32'(fb), 32'h0);
      rdc(`WSCR_IDX_EWAKE, 32'hA7);
      rdc(`WSCR_IDX_IRQ_STAT, 32'h1);
      chk(32'(irq), 32'h1);
      wr(`WSCR_IDX_IRQ_EN, 8'h00);
      chk(32'(irq), 32'h0);
      wr(`WSCR_IDX_IRQ_EN, 8'h07);
      wr(`WSCR_IDX_IRQ_CLR, 8'h01);
      rdc(`WSCR_IDX_IRQ_CLR, 32'h0);
      chk(32'(irq), 32'h0);
      wr(`WSCR_IDX_BUS2, 8'h21);
      wr(`WSCR_IDX_EWAKE, 8'hA5);
      val <= 2'h2;
      pulse(5'h04);
      rdc(`WSCR_IDX_BUS2, 32'h22);
      rdc(`WSCR_IDX_EWAKE, 32'hA5);
      pulse(5'h01);
      rdc(`WSCR_IDX_BUS2, 32'h00);
      rdc(`WSCR_IDX_EWAKE, 32'h07);
      rdc(`WSCR_IDX_BIAS, 32'h00);
      val <= 2'h1;
      // Device updates land in the data phase of a host write
      fork
         wr(`WSCR_IDX_BUS2, 8'h23);
         begin
            @(posedge clk);
            pulse(5'h18);
         end
      join
      chk(32'(second_lin_transceiver_mode), 32'h1);
      chk(32'(peak), 32'h1);
      rdc(`WSCR_IDX_TWAKE, 32'h04);
      rdc(`WSCR_IDX_IRQ_STAT, 32'h6);
      conclude();
   end
endmodule
